// ==== sac_defines.svh ====
// constants for the successive approximation converter control block
// --------------------------------------------------------------------
// Function
// R01: conversion lasts exactly 32 conversion clock ticks
// R02: top reference codes FF, ground codes 00
// R03: sample at start, then eight binary search steps
// R04: done flag sets when result is loaded
// R05: control write or result read clears done
// R06: converts back to back until control written
// R07: each new result overwrites, done flag regardless
// R08: rc select runs converter from rc ticks
// R09: software picks rc only below 1 MHz
// R10: with rc clock, software polls done flag
// R11: power on enables; results wait power settle
// R12: channels 0 to 3 map port bits 6..3
// R13: codes 4,5,6 pick reference, midpoint, ground
// R14: reserved code 7 always yields 00
// R15: powered and codes 0-4 force pin to input
// R16: powered shared channel reads port bit as 0
// R17: wait and halt leave converter running
// R18: software clears power and rc before idling
// R19: stop mode aborts and halts all activity
// R20: stop recovery needs no extra settle wait
// R21: control write while powered restarts sequence
// --------------------------------------------------------------------
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
`define SAC_OFF_CTRL 12'h000
`define SAC_OFF_RES 12'h004
`define SAC_BIT_DONE 7
`define SAC_BIT_RC 6
`define SAC_BIT_PWR 5
`define SAC_BIT_SETTLED 4
`define SAC_SEL_HI 2
`define SAC_SEL_LO 0
`define SAC_CTRL_RST 8'h00
`define SAC_RES_RST 8'h00
`define SAC_CNT_LAST 5'h1F
`define SAC_CNT_SAMPLE 5'h00
`define SAC_CNT_SAR_FIRST 5'h10
`define SAC_CNT_SAR_LAST 5'h17
`define SAC_SAR_MSB 8'h80
`define SAC_CODE_ZERO 8'h00
`define SAC_SEL_RSVD 3'h7
`define SAC_SEL_LAST_PIN 3'h4
`define SAC_PIN_REF_MASK 8'h80
`define SAC_PIN_CH0_MASK 8'h40
`define SAC_SETTLE_W 16
`endif

// ==== sac_pkg.sv ====
// types for the successive approximation converter control block
package sac_pkg;
  typedef struct packed {
    logic rc_sel;
    logic pwr_on;
    logic [2:0] sel;
  } sac_ctrl_t;

  typedef enum logic [2:0] {
    SAC_ST_OFF = 3'b001,
    SAC_ST_SETTLE = 3'b010,
    SAC_ST_RUN = 3'b100
  } sac_state_t;

  typedef struct packed {
    logic [7:0] ddr_clr;
    logic [7:0] read_zero;
  } sac_port_ovr_t;
endpackage

// ==== sac_adc_ctrl.sv ====
// control logic of the 8-bit successive approximation converter
`include "sac_defines.svh"

module sac_adc_ctrl #(
  parameter logic [`SAC_SETTLE_W-1:0] PWR_SETTLE_CYC = 16'h0040,
  parameter logic [`SAC_SETTLE_W-1:0] RC_SETTLE_CYC = 16'h0040
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_tick,
  input wire logic stop_mode,
  input wire logic cmp_above,
  output logic [7:0] dac_code,
  output logic sample_hold,
  output logic [2:0] amux_sel,
  output logic analog_pwr,
  output logic rc_osc_en,
  output sac_pkg::sac_port_ovr_t port_ovr,
  output logic conv_done
);

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  wire logic hit_ctrl;
  wire logic hit_res;
  wire logic mapped;
  wire logic setup_ph;
  wire logic access_ph;
  wire logic wr_ctrl;
  wire logic rd_res;

  assign hit_ctrl = (paddr == `SAC_OFF_CTRL);
  assign hit_res = (paddr == `SAC_OFF_RES);
  assign mapped = hit_ctrl | hit_res;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  // zero wait states keep the read-clear timing simple
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign wr_ctrl = access_ph & pwrite & hit_ctrl;
  assign rd_res = access_ph & ~pwrite & hit_res;

  // --------------------------------------------------------------------
  // control and status state
  // --------------------------------------------------------------------
  sac_pkg::sac_ctrl_t ctrl_r;
  sac_pkg::sac_ctrl_t ctrl_nxt;
  sac_pkg::sac_state_t state_r;
  sac_pkg::sac_state_t state_nxt;
  logic [7:0] result_r;
  logic [7:0] result_nxt;
  logic done_r;
  logic done_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [7:0] sar_r;
  logic [7:0] sar_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] dac_r;
  logic [7:0] dac_nxt;
  logic sample_r;
  logic sample_nxt;
  logic [`SAC_SETTLE_W-1:0] settle_r;
  logic [`SAC_SETTLE_W-1:0] settle_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  wire logic [7:0] ctrl_rd;
  wire logic settled;
  wire logic conv_tick;
  wire logic in_sar;
  wire logic last_tick;
  wire logic keep_bit;
  wire logic [7:0] sar_step;
  wire logic [7:0] mask_step;
  wire logic [7:0] final_code;
  wire logic pwr_rise;
  wire logic rc_rise;
  wire logic [`SAC_SETTLE_W-1:0] pwr_load;
  wire logic [7:0] ctrl_rst_word;
  wire sac_pkg::sac_ctrl_t ctrl_rst;

  // reset value built field by field so the register layout stays the one source
  assign ctrl_rst_word = `SAC_CTRL_RST;
  assign ctrl_rst = {ctrl_rst_word[`SAC_BIT_RC], ctrl_rst_word[`SAC_BIT_PWR],
                     ctrl_rst_word[`SAC_SEL_HI:`SAC_SEL_LO]};

  assign settled = (settle_r == '0);
  assign ctrl_rd = {done_r, ctrl_r.rc_sel, ctrl_r.pwr_on, settled, 1'b0, ctrl_r.sel};

  // --------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.rc_sel = pwdata[`SAC_BIT_RC];
      ctrl_nxt.pwr_on = pwdata[`SAC_BIT_PWR];
      ctrl_nxt.sel = pwdata[`SAC_SEL_HI:`SAC_SEL_LO];
    end
  end

  assign pwr_rise = ctrl_nxt.pwr_on & ~ctrl_r.pwr_on;
  assign rc_rise = ctrl_nxt.rc_sel & ~ctrl_r.rc_sel;
  // power and rc switched on together: the longer settle time is loaded
  assign pwr_load = (rc_rise && (RC_SETTLE_CYC > PWR_SETTLE_CYC)) ? RC_SETTLE_CYC : PWR_SETTLE_CYC;

  // --------------------------------------------------------------------
  // settle timer
  // --------------------------------------------------------------------
  // power-up and rc start each reload; the longer wait wins
  always_comb begin
    settle_nxt = settle_r;
    if (!ctrl_nxt.pwr_on) begin
      settle_nxt = '0;
    end else if (pwr_rise) begin
      settle_nxt = pwr_load; // R11
    end else if (rc_rise && RC_SETTLE_CYC > settle_r) begin
      settle_nxt = RC_SETTLE_CYC; // R08
    end else if (!settled && !stop_mode) begin
      settle_nxt = settle_r - 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // conversion clock select
  // --------------------------------------------------------------------
  // rc ticks arrive already synchronised; bus mode ticks every cycle
  assign conv_tick = ctrl_r.rc_sel ? rc_tick : 1'b1; // R08
  assign in_sar = (cnt_r >= `SAC_CNT_SAR_FIRST) && (cnt_r <= `SAC_CNT_SAR_LAST);
  // a conversion ending as stop begins is abandoned, not reported
  assign last_tick = conv_tick && (cnt_r == `SAC_CNT_LAST) && !stop_mode; // R19

  // --------------------------------------------------------------------
  // binary search step
  // --------------------------------------------------------------------
  // comparator judges the registered trial code: the MSB one from the sample tick, later ones from the tick before
  assign keep_bit = cmp_above; // R03
  assign sar_step = keep_bit ? dac_r : sar_r; // R02
  assign mask_step = mask_r >> 1;
  assign final_code = (ctrl_r.sel == `SAC_SEL_RSVD) ? `SAC_CODE_ZERO : sar_r; // R14

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sar_nxt = sar_r;
    mask_nxt = mask_r;
    dac_nxt = dac_r;
    sample_nxt = 1'b0;
    result_nxt = result_r;
    done_nxt = done_r;
    if (wr_ctrl || rd_res) begin
      done_nxt = 1'b0; // R05
    end
    case (state_r)
      sac_pkg::SAC_ST_OFF: begin
        cnt_nxt = `SAC_CNT_SAMPLE;
        if (ctrl_r.pwr_on && !stop_mode) begin
          state_nxt = sac_pkg::SAC_ST_SETTLE; // R11 R20
        end
      end
      sac_pkg::SAC_ST_SETTLE: begin
        cnt_nxt = `SAC_CNT_SAMPLE;
        if (settled) begin
          state_nxt = sac_pkg::SAC_ST_RUN;
        end
      end
      sac_pkg::SAC_ST_RUN: begin
        if (conv_tick) begin
          cnt_nxt = cnt_r + 1'b1; // R01
          if (cnt_r == `SAC_CNT_SAMPLE) begin
            sample_nxt = 1'b1; // R03
            sar_nxt = `SAC_CODE_ZERO;
            mask_nxt = `SAC_SAR_MSB;
            dac_nxt = `SAC_SAR_MSB;
          end else if (in_sar) begin
            sar_nxt = sar_step;
            mask_nxt = mask_step;
            dac_nxt = sar_step | mask_step;
          end
        end
        if (last_tick) begin
          cnt_nxt = `SAC_CNT_SAMPLE; // R06
          result_nxt = final_code; // R07
          done_nxt = 1'b1; // R04
        end
      end
      default: begin
        state_nxt = sac_pkg::SAC_ST_OFF;
      end
    endcase
    // a new control write throws the running sequence away
    if (wr_ctrl && ctrl_nxt.pwr_on) begin
      state_nxt = sac_pkg::SAC_ST_SETTLE; // R21
      cnt_nxt = `SAC_CNT_SAMPLE;
    end
    if (!ctrl_nxt.pwr_on || stop_mode) begin
      state_nxt = sac_pkg::SAC_ST_OFF; // R19
      cnt_nxt = `SAC_CNT_SAMPLE;
      sample_nxt = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // bus read data
  // --------------------------------------------------------------------
  // captured in setup so the access phase shows flop data
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_ph) begin
      prdata_nxt = '0;
      if (hit_ctrl) begin
        prdata_nxt[7:0] = ctrl_rd;
      end else if (hit_res) begin
        prdata_nxt[7:0] = result_r;
      end
    end
  end

  // --------------------------------------------------------------------
  // flip-flops
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_r <= ctrl_rst;
      state_r <= sac_pkg::SAC_ST_OFF;
      result_r <= `SAC_RES_RST;
      done_r <= 1'b0;
      cnt_r <= `SAC_CNT_SAMPLE;
      sar_r <= `SAC_CODE_ZERO;
      mask_r <= `SAC_CODE_ZERO;
      dac_r <= `SAC_CODE_ZERO;
      sample_r <= 1'b0;
      settle_r <= '0;
      prdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      state_r <= state_nxt;
      result_r <= result_nxt;
      done_r <= done_nxt;
      cnt_r <= cnt_nxt;
      sar_r <= sar_nxt;
      mask_r <= mask_nxt;
      dac_r <= dac_nxt;
      sample_r <= sample_nxt;
      settle_r <= settle_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // --------------------------------------------------------------------
  // analog and port outputs
  // --------------------------------------------------------------------
  // wait and halt have no input here: the converter simply keeps running
  wire logic pin_chan;
  wire logic [7:0] pin_mask;

  assign pin_chan = ctrl_r.pwr_on && (ctrl_r.sel <= `SAC_SEL_LAST_PIN);
  // channel 0..3 -> bit 6..3, channel 4 -> bit 7
  assign pin_mask = (ctrl_r.sel == `SAC_SEL_LAST_PIN) ? `SAC_PIN_REF_MASK :
                    (`SAC_PIN_CH0_MASK >> ctrl_r.sel); // R12 R13

  assign port_ovr.ddr_clr = pin_chan ? pin_mask : 8'h00; // R15
  assign port_ovr.read_zero = pin_chan ? pin_mask : 8'h00; // R16
  assign amux_sel = ctrl_r.sel; // R13
  assign analog_pwr = ctrl_r.pwr_on & ~stop_mode; // R17 R19
  assign rc_osc_en = ctrl_r.rc_sel & ~stop_mode;
  assign dac_code = dac_r;
  assign sample_hold = sample_r;
  assign conv_done = done_r;
  assign prdata = prdata_r;

endmodule

// ==== sac_adc_props.sv ====
// checker of the converter control ports
module sac_adc_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_mode,
  input wire logic sample_hold,
  input wire logic [2:0] amux_sel,
  input wire logic analog_pwr,
  input wire logic rc_osc_en,
  input wire sac_pkg::sac_port_ovr_t port_ovr,
  input wire logic conv_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] cnt_r;
  wire acc = psel && penable;
  wire ctl_wr = acc && pwrite && paddr == 12'h000;
  wire res_rd = acc && !pwrite && paddr == 12'h004;
  wire [7:0] pin_mask = amux_sel == 3'h4 ? 8'h80 : amux_sel[2] ? 8'h00 : 8'h40 >> amux_sel;
  wire [7:0] exp_mask = analog_pwr ? pin_mask : 8'h00;
  // ----
  // cycles since conversion start
  // ----
  // a control write, power loss or rc source breaks the bus-clock cadence
  always_ff @(posedge core_clk) begin
    if (!rst_n || ctl_wr || !analog_pwr || rc_osc_en) cnt_r <= 6'h00;
    else if (sample_hold) cnt_r <= 6'h01;
    else if (cnt_r != 6'h00 && cnt_r != 6'h3F) cnt_r <= cnt_r + 6'h01;
  end
  sequence s_early_rd;
    res_rd && cnt_r inside {[6'h01:6'h18]};
  endsequence
  a_conv_period: assert property (cnt_r == 6'h20 |-> sample_hold)
    else $error("conversion start not 32 cycles after previous");
  a_no_early: assert property (cnt_r inside {[6'h02:6'h1F]} |-> !sample_hold)
    else $error("conversion restarted early");
  a_done_timing: assert property ($rose(conv_done) && cnt_r != 6'h00 |-> cnt_r == 6'h1F)
    else $error("done flag set at wrong count");
  a_wr_clears: assert property (ctl_wr && cnt_r inside {[6'h01:6'h14]} |=> !conv_done)
    else $error("control write left done set");
  a_rd_clears: assert property (s_early_rd |=> !conv_done)
    else $error("result read left done set");
  a_stop_halts: assert property (stop_mode && $past(stop_mode) |->
    !sample_hold && !analog_pwr && !rc_osc_en && !$rose(conv_done))
    else $error("activity during stop");
  a_pin_force: assert property (!stop_mode |->
    port_ovr.ddr_clr == exp_mask && port_ovr.read_zero == exp_mask)
    else $error("port override mask wrong");
  a_bus_resp: assert property (acc |-> pready && pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("bus response wrong");
endmodule

// ==== sac_ana_model.sv ====
// analog front end model: sample hold and comparator
module sac_ana_model (
  input wire logic core_clk,
  input wire logic sample_hold,
  input wire logic [2:0] amux_sel,
  input wire logic [7:0] dac_code,
  input wire logic [31:0] pin_lvl,
  output logic cmp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held_r;
  logic [7:0] lvl;
  always_comb begin
    case (amux_sel)
      3'h4: lvl = 8'hFF;
      3'h5: lvl = 8'h80;
      3'h6: lvl = 8'h00;
      3'h7: lvl = 8'hA5; // reserved tap shows junk, design must hide it
      default: lvl = pin_lvl[amux_sel[1:0]*8 +: 8];
    endcase
  end
  always_ff @(posedge core_clk) if (sample_hold) held_r <= lvl;
  // ideal comparator, so the search lands on the held level exactly
  assign cmp_above = held_r >= dac_code;
endmodule

// ==== testbench.sv ====
// self-checking bench of the converter control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, psel, penable, pwrite, rc_tick, stop_mode, rc_run, cmp_above;
  logic pready, pslverr, sample_hold, analog_pwr, rc_osc_en, conv_done, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, pin_lvl;
  logic [7:0] dac_code;
  logic [2:0] amux_sel;
  logic [1:0] div_r;
  sac_pkg::sac_port_ovr_t port_ovr;
  int num_errors = 0;
  int num_checks = 0;
  int i;
  sac_adc_ctrl #(.PWR_SETTLE_CYC(16'h0002), .RC_SETTLE_CYC(16'h0002)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_tick(rc_tick), .stop_mode(stop_mode), .cmp_above(cmp_above), .dac_code(dac_code),
    .sample_hold(sample_hold), .amux_sel(amux_sel), .analog_pwr(analog_pwr),
    .rc_osc_en(rc_osc_en), .port_ovr(port_ovr), .conv_done(conv_done));
  sac_ana_model model (.core_clk(core_clk), .sample_hold(sample_hold), .amux_sel(amux_sel),
    .dac_code(dac_code), .pin_lvl(pin_lvl), .cmp_above(cmp_above));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // slow stand-in for the rc oscillator, one tick every fourth cycle
  always @(posedge core_clk) begin
    div_r <= rst_n ? div_r + 2'h1 : 2'h0;
    rc_tick <= rst_n && rc_run && div_r == 2'h3;
  end
  // ----
  // check, verdict and bus tasks
  // ----
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a hung bus counts once and the run carries on to the closing report
    if (pready !== 1'b1) begin
      num_errors++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // polling, since an rc-clocked count has no fixed cycle figure
  task wait_done;
    int n;
    n = 0;
    do begin
      xfer(12'h000, 1'b0, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 400);
    if (rd[7] !== 1'b1) begin
      num_errors++;
    end
  endtask
  task conv(input logic [2:0] s, input logic rc, input logic [7:0] exp);
    xfer(12'h000, 1'b1, {25'h0, rc, 1'b1, 2'b00, s});
    wait_done;
    chk("control", rd & 32'h7F, {25'h0, rc, 1'b1, 2'b10, s});
    xfer(12'h004, 1'b0, 32'h0);
    chk("result", rd, {24'h0, exp});
    xfer(12'h000, 1'b0, 32'h0);
    chk("done after read", {31'h0, rd[7]}, 32'h0);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {rst_n, psel, penable, pwrite, stop_mode, rc_run} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin_lvl = 32'hFE01C35A;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    xfer(12'h000, 1'b0, 32'h0);
    chk("control reset", rd, 32'h10);
    xfer(12'h004, 1'b0, 32'h0);
    chk("result reset", rd, 32'h0);
    xfer(12'h008, 1'b1, 32'hFF);
    chk("unmapped error", {31'h0, err}, 32'h1);
    xfer(12'h008, 1'b0, 32'h0);
    chk("unmapped read", rd, 32'h0);
    $display("test reset and map finished");
    for (i = 0; i < 8; i++) conv(i[2:0], 1'b0, i < 4 ? pin_lvl[i*8 +: 8] :
      i == 4 ? 8'hFF : i == 5 ? 8'h80 : 8'h00);
    $display("test channels finished");
    xfer(12'h000, 1'b1, 32'h20);
    wait_done;
    pin_lvl[7:0] <= 8'h33;
    repeat (70) @(posedge core_clk);
    xfer(12'h004, 1'b0, 32'h0);
    chk("overwrite", rd, 32'h33);
    wait_done;
    xfer(12'h000, 1'b1, 32'h21);
    xfer(12'h000, 1'b0, 32'h0);
    chk("done after write", {31'h0, rd[7]}, 32'h0);
    $display("test continuous finished");
    rc_run <= 1'b1;
    conv(3'h1, 1'b1, 8'hC3);
    chk("rc enable", {31'h0, rc_osc_en}, 32'h1);
    rc_run <= 1'b0;
    $display("test rc clock finished");
    xfer(12'h000, 1'b1, 32'h22);
    repeat (10) @(posedge core_clk);
    stop_mode <= 1'b1;
    repeat (60) @(posedge core_clk);
    chk("stop power", {30'h0, analog_pwr, rc_osc_en}, 32'h0);
    xfer(12'h000, 1'b0, 32'h0);
    chk("stop done", {31'h0, rd[7]}, 32'h0);
    stop_mode <= 1'b0;
    wait_done;
    xfer(12'h004, 1'b0, 32'h0);
    chk("after stop", rd, 32'h01);
    $display("test stop finished");
    xfer(12'h000, 1'b1, 32'h00);
    chk("idle", {15'h0, analog_pwr, port_ovr}, 32'h0);
    $display("test idle finished");
    print_verdict;
  end
endmodule
bind sac_adc_ctrl sac_adc_props props (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .stop_mode(stop_mode), .sample_hold(sample_hold), .amux_sel(amux_sel),
  .analog_pwr(analog_pwr), .rc_osc_en(rc_osc_en), .port_ovr(port_ovr), .conv_done(conv_done));
